// ### timer_csr_regs.vh
/*
  Register offsets, field positions, mode codes and counter limits of one timer
  control/status block. Assumes inclusion by bare name from the design files.
*/
`ifndef TIMER_CSR_REGS_VH
`define TIMER_CSR_REGS_VH

`define TMR_OFS_CTRL        2'h0
`define TMR_OFS_LOAD        2'h1
`define TMR_OFS_COMPARE     2'h2
`define TMR_OFS_COUNT       2'h3

`define TMR_RUN_BIT         0
`define TMR_OVF_IE_BIT      1
`define TMR_CMP_IE_BIT      2
`define TMR_MODE_LSB        4
`define TMR_MODE_MSB        7
`define TMR_CTRL_MASK       24'h00_00F7
`define TMR_CTRL_RESET      24'h00_0000

`define TMR_MODE_GPIO       4'h0
`define TMR_MODE_PULSE      4'h1
`define TMR_MODE_TOGGLE     4'h2
`define TMR_MODE_EVENT      4'h3
`define TMR_MODE_WIDTH      4'h4
`define TMR_MODE_PERIOD     4'h5
`define TMR_MODE_CAPTURE    4'h6
`define TMR_MODE_PWM        4'h7
`define TMR_MODE_WD_PULSE   4'h9
`define TMR_MODE_WD_TOGGLE  4'hA

`define TMR_COUNT_MAX       24'hFF_FFFF
`define TMR_COUNT_ZERO      24'h00_0000

`endif

// ### pin_edge_sync.v
/*
  Two-flop synchroniser with an edge detector behind the second flop.
  Assumes the pin toggles slower than a quarter of the core clock.
*/
module pin_edge_sync (
  input  wire clk_in,
  input  wire reset_in,
  input  wire pin_in,
  output reg  level_out,
  output wire rise_out
);
  reg meta_ff;
  reg last_ff;

  // The first flop feeds only the second, so a metastable value never fans out.
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_ff   <= 1'b0;
      level_out <= 1'b0;
      last_ff   <= 1'b0;
    end else begin
      meta_ff   <= pin_in;
      level_out <= meta_ff;
      last_ff   <= level_out;
    end
  end

  assign rise_out = level_out & ~last_ff;
endmodule // pin_edge_sync

// ### mode_decode.v
/*
  Decodes the 4-bit mode field into clock source, pin direction and mode class.
  Assumes timer 0 when HAS_PIN is 1; other timers accept only mode 0.
*/
`include "timer_csr_regs.vh"
module mode_decode #(
  parameter HAS_PIN = 1
) (
  input  wire [3:0] mode_in,
  output reg        valid_out,
  output reg        ext_clk_out,
  output reg        pin_drive_out,
  output reg        gpio_out,
  output reg        cmp_mode_out
);
  always @* begin
    valid_out     = 1'b1;
    ext_clk_out   = 1'b0;
    pin_drive_out = 1'b0;
    gpio_out      = 1'b0;
    cmp_mode_out  = 1'b0;
    if (HAS_PIN == 0) begin
      valid_out    = (mode_in == `TMR_MODE_GPIO);
      cmp_mode_out = (mode_in == `TMR_MODE_GPIO);
    end else begin
      case (mode_in)
        `TMR_MODE_GPIO: begin
          gpio_out     = 1'b1;
          cmp_mode_out = 1'b1;
        end
        `TMR_MODE_PULSE, `TMR_MODE_TOGGLE: begin
          pin_drive_out = 1'b1;
          cmp_mode_out  = 1'b1;
        end
        `TMR_MODE_EVENT: begin
          ext_clk_out  = 1'b1;
          cmp_mode_out = 1'b1;
        end
        `TMR_MODE_WIDTH, `TMR_MODE_PERIOD, `TMR_MODE_CAPTURE: begin
          valid_out = 1'b1;
        end
        `TMR_MODE_PWM, `TMR_MODE_WD_PULSE, `TMR_MODE_WD_TOGGLE: begin
          pin_drive_out = 1'b1;
          cmp_mode_out  = 1'b1;
        end
        default: begin
          valid_out = 1'b0;
        end
      endcase
    end
  end
endmodule // mode_decode

// ### timer_control_status.v
/*
  Control and status logic of one 24-bit timer/event counter: run bit,
  interrupt enables, mode field, counter, load and compare registers.
  Assumes a simple synchronous register port and a single core clock;
  the shared pin is split into input, output and output enable.
*/
// Behaviour
// - Setting run enables timer and clears counter; clearing run disables it.
// - Run, enables and mode clear on hardware reset or software reset.
// - Timer 0 disabled and not in GPIO mode releases the shared pin.
// - Counter wraps max to zero; overflow interrupt only when its enable set.
// - Timer, PWM, watchdog modes raise compare interrupt on match when enabled.
// - Counter counts up from load value M; interrupt after N-M+1 events.
// - Mode field bits 7..4 select clock source, pin behaviour, operating mode.
// - External clock counts synchronised rising edges of the shared pin.
// - Modes 0-3: timer/GPIO, pulse, toggle on internal clock, event counter.
// - Modes 4-7, 9, 10 use internal clock; 8 and 11-15 reserved.
// - GPIO function of the pin only when mode field is all zero.
// - Timers 1 and 2 support only mode zero.
// - Timer and watchdog modes preload the load value on the first event.
`include "timer_csr_regs.vh"
module timer_control_status #(
  parameter HAS_PIN = 1,
  parameter WIDTH   = 24
) (
  input  wire             CORE_CLK_IN,
  input  wire             RESET_IN,
  input  wire             SOFT_RESET_IN,
  input  wire             TICK_IN,
  input  wire             REG_WRITE_IN,
  input  wire [1:0]       REG_ADDR_IN,
  input  wire [WIDTH-1:0] REG_WDATA_IN,
  output reg  [WIDTH-1:0] REG_RDATA_OUT,
  input  wire             GPIO_DIR_IN,
  input  wire             GPIO_DATA_IN,
  input  wire             PIN_IN,
  output reg              PIN_OUT,
  output wire             PIN_OE_OUT,
  output reg              OVERFLOW_IRQ_OUT,
  output reg              COMPARE_IRQ_OUT
);
  reg  [WIDTH-1:0] ctrl_ff;
  reg  [WIDTH-1:0] load_ff;
  reg  [WIDTH-1:0] compare_ff;
  reg  [WIDTH-1:0] count_ff;
  reg  [WIDTH-1:0] nxt_count;
  reg              primed_ff;
  reg              nxt_primed;
  reg              toggle_ff;
  wire             timer_run_bit;
  wire             overflow_irq_enable;
  wire             compare_irq_enable;
  wire [3:0]       timer_mode_field;
  wire             mode_valid;
  wire             mode_ext_clk;
  wire             mode_pin_drive;
  wire             mode_gpio;
  wire             mode_cmp;
  wire             pin_rise;
  wire             event_tick;
  wire             wrap;
  wire             match;
  wire             run_set;

  assign timer_run_bit       = ctrl_ff[`TMR_RUN_BIT];
  assign overflow_irq_enable = ctrl_ff[`TMR_OVF_IE_BIT];
  assign compare_irq_enable  = ctrl_ff[`TMR_CMP_IE_BIT];
  assign timer_mode_field    = ctrl_ff[`TMR_MODE_MSB:`TMR_MODE_LSB];

  mode_decode #(
    .HAS_PIN (HAS_PIN)
  ) u_decode (
    .mode_in       (timer_mode_field),
    .valid_out     (mode_valid),
    .ext_clk_out   (mode_ext_clk),
    .pin_drive_out (mode_pin_drive),
    .gpio_out      (mode_gpio),
    .cmp_mode_out  (mode_cmp)
  );

  pin_edge_sync u_sync (
    .clk_in    (CORE_CLK_IN),
    .reset_in  (RESET_IN),
    .pin_in    (PIN_IN),
    .level_out (),
    .rise_out  (pin_rise)
  );

  assign event_tick = timer_run_bit & mode_valid & (mode_ext_clk ? pin_rise : TICK_IN);
  assign wrap       = event_tick & primed_ff & (count_ff == `TMR_COUNT_MAX);
  assign match      = event_tick & (nxt_count == compare_ff);
  assign run_set    = REG_WRITE_IN & (REG_ADDR_IN == `TMR_OFS_CTRL)
                      & REG_WDATA_IN[`TMR_RUN_BIT] & ~timer_run_bit;

  always @* begin
    nxt_count  = count_ff;
    nxt_primed = primed_ff;
    if (event_tick) begin
      if (!primed_ff) begin
        nxt_count  = load_ff;
        nxt_primed = 1'b1;
      end else begin
        nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Software reset is synchronous so it cannot glitch the async path.
  always @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ctrl_ff          <= `TMR_CTRL_RESET;
      load_ff          <= {WIDTH{1'b0}};
      compare_ff       <= {WIDTH{1'b0}};
      count_ff         <= {WIDTH{1'b0}};
      primed_ff        <= 1'b0;
      toggle_ff        <= 1'b0;
      OVERFLOW_IRQ_OUT <= 1'b0;
      COMPARE_IRQ_OUT  <= 1'b0;
    end else if (SOFT_RESET_IN) begin
      ctrl_ff          <= `TMR_CTRL_RESET;
      count_ff         <= {WIDTH{1'b0}};
      primed_ff        <= 1'b0;
      toggle_ff        <= 1'b0;
      OVERFLOW_IRQ_OUT <= 1'b0;
      COMPARE_IRQ_OUT  <= 1'b0;
    end else begin
      if (REG_WRITE_IN && REG_ADDR_IN == `TMR_OFS_CTRL) begin
        ctrl_ff <= REG_WDATA_IN & `TMR_CTRL_MASK;
      end
      if (REG_WRITE_IN && REG_ADDR_IN == `TMR_OFS_LOAD) begin
        load_ff <= REG_WDATA_IN;
      end
      if (REG_WRITE_IN && REG_ADDR_IN == `TMR_OFS_COMPARE) begin
        compare_ff <= REG_WDATA_IN;
      end
      if (run_set) begin
        count_ff  <= `TMR_COUNT_ZERO;
        primed_ff <= 1'b0;
      end else begin
        count_ff  <= nxt_count;
        primed_ff <= nxt_primed;
      end
      OVERFLOW_IRQ_OUT <= wrap & overflow_irq_enable;
      COMPARE_IRQ_OUT  <= match & mode_cmp & compare_irq_enable;
      if (match && mode_pin_drive) begin
        toggle_ff <= ~toggle_ff;
      end
    end
  end

  assign PIN_OE_OUT = (HAS_PIN != 0) &
                      ((mode_gpio & GPIO_DIR_IN) | (timer_run_bit & mode_pin_drive));

  always @* begin
    if (mode_gpio) begin
      PIN_OUT = GPIO_DATA_IN;
    end else begin
      PIN_OUT = toggle_ff;
    end
  end

  always @* begin
    case (REG_ADDR_IN)
      `TMR_OFS_CTRL:    REG_RDATA_OUT = ctrl_ff;
      `TMR_OFS_LOAD:    REG_RDATA_OUT = {WIDTH{1'b0}};
      `TMR_OFS_COMPARE: REG_RDATA_OUT = compare_ff;
      default:          REG_RDATA_OUT = count_ff;
    endcase
  end
endmodule // timer_control_status

// ### timer_csr_chk_asserts.sv
/* Port checker of one timer control block.
   Assumes binding to the timer top module and one core clock. */
`include "timer_csr_regs.vh"
module timer_csr_chk #(
  parameter HAS_PIN = 1,
  parameter WIDTH   = 24
) (
  input wire logic             CORE_CLK_IN,
  input wire logic             RESET_IN,
  input wire logic             SOFT_RESET_IN,
  input wire logic             TICK_IN,
  input wire logic             REG_WRITE_IN,
  input wire logic [1:0]       REG_ADDR_IN,
  input wire logic [WIDTH-1:0] REG_WDATA_IN,
  input wire logic [WIDTH-1:0] REG_RDATA_OUT,
  input wire logic             GPIO_DIR_IN,
  input wire logic             GPIO_DATA_IN,
  input wire logic             PIN_IN,
  input wire logic             PIN_OUT,
  input wire logic             PIN_OE_OUT,
  input wire logic             OVERFLOW_IRQ_OUT,
  input wire logic             COMPARE_IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WIDTH-1:0] ctrl_ff;
  logic [3:0]       mode;
  logic             rsv;
  assign mode = ctrl_ff[`TMR_MODE_MSB:`TMR_MODE_LSB];
  assign rsv  = HAS_PIN ? (mode == 4'h8 || mode > 4'hA) : (mode != 4'h0);
  // Shadow built from writes and resets alone, so a stuck control register shows up.
  always @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) ctrl_ff <= '0;
    else if (SOFT_RESET_IN) ctrl_ff <= '0;
    else if (REG_WRITE_IN && REG_ADDR_IN == `TMR_OFS_CTRL) ctrl_ff <= REG_WDATA_IN & `TMR_CTRL_MASK;
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  property p_ovf_en; OVERFLOW_IRQ_OUT |-> $past(ctrl_ff[1]); endproperty
  a_ovf_en: assert property (p_ovf_en) else $error("overflow pulse while disabled");
  property p_ovf_one; OVERFLOW_IRQ_OUT |=> !OVERFLOW_IRQ_OUT; endproperty
  a_ovf_one: assert property (p_ovf_one) else $error("overflow pulse too long");
  property p_cmp_en; COMPARE_IRQ_OUT |-> $past(ctrl_ff[2]) && ($past(TICK_IN) || $past(mode) == 4'h3); endproperty
  a_cmp_en: assert property (p_cmp_en) else $error("compare pulse without cause");
  property p_pin_off; !ctrl_ff[0] && mode != 4'h0 |-> !PIN_OE_OUT; endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while stopped");
  property p_gpio; mode == 4'h0 |-> PIN_OE_OUT == GPIO_DIR_IN && (!GPIO_DIR_IN || PIN_OUT == GPIO_DATA_IN); endproperty
  a_gpio: assert property (p_gpio) else $error("gpio pin mismatch");
  property p_rsv; rsv |-> !PIN_OE_OUT && !COMPARE_IRQ_OUT && !OVERFLOW_IRQ_OUT; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved mode active");
  property p_ctrl_rd; REG_ADDR_IN == `TMR_OFS_CTRL |-> REG_RDATA_OUT == ctrl_ff; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
  property p_run_clr; (REG_WRITE_IN && REG_ADDR_IN == 2'h0 && REG_WDATA_IN[0] && !ctrl_ff[0]) ##1 !TICK_IN
    ##1 REG_ADDR_IN == `TMR_OFS_COUNT |-> REG_RDATA_OUT == '0; endproperty
  a_run_clr: assert property (p_run_clr) else $error("count not cleared on start");
endmodule // timer_csr_chk
bind timer_control_status timer_csr_chk #(.HAS_PIN(HAS_PIN), .WIDTH(WIDTH)) chk_u (
  .CORE_CLK_IN      (CORE_CLK_IN),
  .RESET_IN         (RESET_IN),
  .SOFT_RESET_IN    (SOFT_RESET_IN),
  .TICK_IN          (TICK_IN),
  .REG_WRITE_IN     (REG_WRITE_IN),
  .REG_ADDR_IN      (REG_ADDR_IN),
  .REG_WDATA_IN     (REG_WDATA_IN),
  .REG_RDATA_OUT    (REG_RDATA_OUT),
  .GPIO_DIR_IN      (GPIO_DIR_IN),
  .GPIO_DATA_IN     (GPIO_DATA_IN),
  .PIN_IN           (PIN_IN),
  .PIN_OUT          (PIN_OUT),
  .PIN_OE_OUT       (PIN_OE_OUT),
  .OVERFLOW_IRQ_OUT (OVERFLOW_IRQ_OUT),
  .COMPARE_IRQ_OUT  (COMPARE_IRQ_OUT)
);

// ### pin_source.sv
/* Signal source on the shared timer pin for event counting.
   Assumes a pull-down on the pin and the core clock. */
module pin_source (
  input  wire logic clk_in,
  input  wire logic go_in,
  input  wire logic oe_in,
  input  wire logic out_in,
  output wire logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic src_ff = 1'b0;
  int   cnt    = 0;
  always @(posedge clk_in) begin
    if (go_in) cnt <= 24;
    else if (cnt > 0) cnt <= cnt - 1;
    if (cnt % 3 == 1) src_ff <= ~src_ff;
  end
  // An undriven pin takes src_ff, which idles low, so release adds no rising edge.
  assign pin_out = oe_in ? out_in : src_ff;
endmodule // pin_source

// ### tb.sv
/* Self-checking bench of the timer control block.
   Assumes the 50 MHz core clock and the pin source model. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, srst = 0, tk = 0, we = 0, dir = 0, dat = 0, go = 0;
  logic [1:0]  adr = 2'h0;
  logic [23:0] wd  = 24'h00_0000;
  logic [6:0]  rows [0:17];
  wire  [23:0] rd;
  wire         pin, po, oe, ovf, cmp;
  int          bad_count = 0, n_checks = 0, n_ovf = 0, n_cmp = 0;
  initial forever #10 clk = ~clk;
  timer_control_status dut_u (.CORE_CLK_IN(clk), .RESET_IN(rst), .SOFT_RESET_IN(srst),
    .TICK_IN(tk), .REG_WRITE_IN(we), .REG_ADDR_IN(adr), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rd),
    .GPIO_DIR_IN(dir), .GPIO_DATA_IN(dat), .PIN_IN(pin), .PIN_OUT(po), .PIN_OE_OUT(oe),
    .OVERFLOW_IRQ_OUT(ovf), .COMPARE_IRQ_OUT(cmp));
  pin_source src_u (.clk_in(clk), .go_in(go), .oe_in(oe), .out_in(po), .pin_out(pin));
  always @(posedge clk) begin
    n_ovf += int'(ovf === 1'b1);
    n_cmp += int'(cmp === 1'b1);
  end
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    chk(nm, {23'h00_0000, e}, {23'h00_0000, g});
  endtask
  task automatic wr(logic [1:0] a, logic [23:0] d);
    @(posedge clk);
    we  <= 1'b1;
    adr <= a;
    wd  <= d;
    @(posedge clk);
    we  <= 1'b0;
  endtask
  task automatic rdc(logic [1:0] a, logic [23:0] e);
    @(posedge clk);
    adr <= a;
    #1 chk("read data", e, rd);
  endtask
  task automatic ticks(int n);
    repeat (n) begin
      @(posedge clk);
      tk <= 1'b1;
      @(posedge clk);
      tk <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask
  // Mode goes in with run clear, then run is set on its own.
  // Mode before run.
  task automatic start(logic [23:0] c);
    wr(2'h0, c & 24'hFF_FFFE);
    wr(2'h0, c);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rows[0] = 7'h07;
    rows[1] = 7'h05;
    rows[2] = 7'h02;
    for (int m = 1; m < 16; m++) rows[m + 2] = {4'(m), 3'h6};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(2'h0, 24'h00_0000);
    rdc(2'h3, 24'h00_0000);
    foreach (rows[i]) begin
      @(posedge clk);
      dir <= rows[i][2];
      dat <= rows[i][1];
      wr(2'h0, {16'h0000, rows[i][6:3], 4'h0});
      #1 chk1("pin enable", rows[i][0], oe);
      if (rows[i][0]) chk1("pin level", rows[i][1], po);
    end
    dir <= 1'b0;
    wr(2'h1, 24'h00_0005);
    wr(2'h2, 24'h00_0008);
    rdc(2'h2, 24'h00_0008);
    start(24'h00_0005);
    rdc(2'h3, 24'h00_0000);
    n_cmp = 0;
    ticks(1);
    rdc(2'h3, 24'h00_0005);
    ticks(2);
    chk("compare pulses", 24'h00_0000, 24'(n_cmp));
    ticks(1);
    chk("compare pulses", 24'h00_0001, 24'(n_cmp));
    wr(2'h0, 24'h00_0004);
    ticks(2);
    rdc(2'h3, 24'h00_0008);
    wr(2'h0, 24'h00_0005);
    rdc(2'h3, 24'h00_0000);
    wr(2'h0, 24'h00_0000);
    wr(2'h1, 24'hFF_FFFE);
    start(24'h00_0003);
    n_ovf = 0;
    ticks(2);
    rdc(2'h3, 24'hFF_FFFF);
    ticks(1);
    chk("overflow pulses", 24'h00_0001, 24'(n_ovf));
    rdc(2'h3, 24'h00_0000);
    wr(2'h0, 24'h00_0000);
    start(24'h00_0001);
    ticks(3);
    chk("overflow pulses", 24'h00_0001, 24'(n_ovf));
    wr(2'h0, 24'h00_0000);
    wr(2'h1, 24'h00_0000);
    start(24'h00_0081);
    ticks(2);
    rdc(2'h3, 24'h00_0000);
    wr(2'h0, 24'h00_0080);
    start(24'h00_0031);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (35) @(posedge clk);
    rdc(2'h3, 24'h00_0003);
    chk1("pin enable", 1'b0, oe);
    wr(2'h0, 24'h00_0030);
    start(24'h00_0021);
    #1 chk1("pin enable", 1'b1, oe);
    ticks(9);
    chk1("pin level", 1'b1, po);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rdc(2'h0, 24'h00_0000);
    chk1("pin enable", 1'b0, oe);
    end_of_test();
  end
endmodule // tb
